// ---- mode_pkg.sv ----
package mode_pkg;
    // clock rate and the restore hold-off
    localparam int unsigned CLK_MHZ     = 200;
    localparam int unsigned RESTORE_MS  = 4;
    localparam int unsigned RESTORE_CYC = RESTORE_MS * 1000 * CLK_MHZ;

    // phase count
    localparam int unsigned NUM_PHASES = 6;

    // two-bit drive code of one phase output
    localparam logic [1:0] DRV_LOW   = 2'h0;
    localparam logic [1:0] DRV_HIGH  = 2'h1;
    localparam logic [1:0] DRV_FLOAT = 2'h2;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BOOT = 8'h04;
    localparam logic [7:0] ADDR_VID  = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;

    // reset values
    localparam logic [2:0] SLEW_RST = 3'h0;
    localparam logic [7:0] BOOT_RST = 8'h40;
    localparam logic [7:0] VID_RST  = 8'h00;

    // ramp step interval for the fastest slew code, in cycles
    localparam logic [15:0] STEP_BASE_CYC = 16'h0008;
    localparam logic [2:0]  SLEW_MAX      = 3'h7;

    // phase-count strap encodings and their phase masks
    localparam logic [2:0] PH_STRAP_6 = 3'h0;
    localparam logic [2:0] PH_STRAP_4 = 3'h1;
    localparam logic [2:0] PH_STRAP_3 = 3'h2;
    localparam logic [2:0] PH_STRAP_2 = 3'h3;
    localparam logic [2:0] PH_STRAP_1 = 3'h4;
    localparam logic [5:0] PH_MASK_6  = 6'h3f;
    localparam logic [5:0] PH_MASK_4  = 6'h0f;
    localparam logic [5:0] PH_MASK_3  = 6'h07;
    localparam logic [5:0] PH_MASK_2  = 6'h03;
    localparam logic [5:0] PH_MASK_1  = 6'h01;

    // power sequencing states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_WAIT_STAGE,
        ST_SOFT_START,
        ST_RUN,
        ST_RESTORE
    } seq_state_t;
endpackage

// ---- drive_if.sv ----
`timescale 1ns/1ps
// carries phase selection and pin drive between control and output stage
interface drive_if;
    logic [5:0] phase_en;   // phases allowed to switch
    logic [5:0] pwm_raw;    // modulator level per phase
    logic       float_all;  // force every output to mid-level
    logic [5:0] pin_hi;     // registered pin level
    logic [5:0] pin_oe;     // registered pin drive enable

    modport ctrl (
        output phase_en,
        output pwm_raw,
        output float_all,
        input  pin_hi,
        input  pin_oe
    );
    modport stage (
        input  phase_en,
        input  pwm_raw,
        input  float_all,
        output pin_hi,
        output pin_oe
    );
endinterface

// ---- restore_timer.sv ----
`timescale 1ns/1ps
module restore_timer #(
    parameter int unsigned LIMIT = mode_pkg::RESTORE_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // qualification and request
    input  wire logic armed,
    input  wire logic request_n,
    // one-cycle restore event
    output logic      fire
);
    typedef struct packed {
        logic [19:0] cnt;   // consecutive low cycles
        logic        done;  // fired in this low episode
        logic        fire;  // event pulse
    } tmr_t;

    tmr_t s_r;
    tmr_t s_nxt;

    // count low time; only a stretch strictly longer than LIMIT fires
    always_comb begin
        s_nxt      = s_r;
        s_nxt.fire = 1'b0;
        if (!armed || request_n) begin
            // high level or not armed restarts the measurement
            s_nxt.cnt  = '0;
            s_nxt.done = 1'b0;
        end else if (!s_r.done) begin
            if (s_r.cnt == 20'(LIMIT)) begin
                s_nxt.fire = 1'b1;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 20'h00001;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fire = s_r.fire;
endmodule // restore_timer

// ---- pwm_stage.sv ----
`timescale 1ns/1ps
module pwm_stage (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control side
    drive_if.stage    dif
);
    typedef struct packed {
        logic [5:0][1:0] code;  // drive code per phase
        logic [5:0]      hi;    // pin level
        logic [5:0]      oe;    // pin enable
    } stg_t;

    stg_t s_r;
    stg_t s_nxt;

    // per phase: float, or follow the modulator high or low
    always_comb begin
        s_nxt = s_r;
        for (int i = 0; i < 6; i++) begin
            if (dif.float_all || !dif.phase_en[i]) begin
                s_nxt.code[i] = mode_pkg::DRV_FLOAT;
            end else if (dif.pwm_raw[i]) begin
                s_nxt.code[i] = mode_pkg::DRV_HIGH;
            end else begin
                s_nxt.code[i] = mode_pkg::DRV_LOW;
            end
            // pins mirror the code in the same edge
            s_nxt.hi[i] = (s_nxt.code[i] == mode_pkg::DRV_HIGH);
            s_nxt.oe[i] = (s_nxt.code[i] != mode_pkg::DRV_FLOAT);
        end
    end

    // reset floats every output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= {{6{mode_pkg::DRV_FLOAT}}, 6'h00, 6'h00};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dif.pin_hi = s_r.hi;
    assign dif.pin_oe = s_r.oe;
endmodule // pwm_stage

// ---- phase_mode_ctrl.sv ----
`timescale 1ns/1ps
// What this block does
// - enabled only while enable comparator high
// - stage supply good gates up/down sequencing
// - strap picks restore or power-saving function
// - low over 4ms after regulation: restore
// - restore ramp uses soft-start slew
// - high: strapped phases, low: single phase
// - state changes only after output regulates
// - full power follows phase-count strap
// - light load: only first phase switches
// - six outputs driven high or low
// - mid-level request floats the outputs
// - disable or lockout floats all outputs
// - strap selects six/four/three/two/one phases
module phase_mode_ctrl #(
    parameter int unsigned RESTORE_CYC = mode_pkg::RESTORE_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic [31:0]     rdata,
    // enable and supply monitors
    input  wire logic       en_above_threshold,
    input  wire logic       supply_lockout,
    input  wire logic       stage_supply_good,
    input  wire logic       output_in_regulation,
    input  wire logic       fault_mid_level,
    // straps
    input  wire logic       function_select_strap,
    input  wire logic [2:0] phase_count_strap,
    // multi-function pin
    input  wire logic       multi_function_pin,
    // modulator levels
    input  wire logic [5:0] modulator_pwm,
    // phase outputs
    output logic [5:0]      pwm_drive_hi,
    output logic [5:0]      pwm_drive_oe,
    // status
    output logic [7:0]      target_code,
    output logic            device_enabled,
    output logic            full_power_state,
    output logic            light_load_state
);
    // all control state in one record
    typedef struct packed {
        mode_pkg::seq_state_t state;  // sequencing state
        logic [7:0]  target;   // ramped output target
        logic [7:0]  vid;      // target goal
        logic [7:0]  boot;     // boot voltage code
        logic [2:0]  slew;     // soft-start slew code
        logic [15:0] step_cnt; // cycles to next ramp step
        logic        psi_mode; // latched function strap
        logic [5:0]  ph_mask;  // latched phase strap
        logic        enabled;  // comparator and lockout result
        logic        full;     // full power state
        logic        light;    // light load state
        logic [31:0] rdata;    // read answer
    } ctl_t;

    ctl_t s_r;
    ctl_t s_nxt;

    logic       restore_fire;  // restore event from the timer
    logic       restore_arm;   // timer qualification
    logic       enabled_now;   // enable with lockout folded in
    logic       running;       // states that switch the phases
    logic [15:0] step_len;     // ramp interval for current slew
    logic [5:0] ph_strap_mask; // decoded strap

    drive_if dif ();

    // enable decision, comparator and input lockout
    // enable comparator gate
    assign enabled_now = en_above_threshold & ~supply_lockout;

    // phases switch only in soft start, run and restore
    assign running = (s_r.state == mode_pkg::ST_SOFT_START) ||
                     (s_r.state == mode_pkg::ST_RUN) ||
                     (s_r.state == mode_pkg::ST_RESTORE);

    // slower slew codes double the step interval
    // one slew for both ramps
    assign step_len = 16'(mode_pkg::STEP_BASE_CYC
                          << (mode_pkg::SLEW_MAX - s_r.slew));

    // restore watch only in restore function, once regulating
    // qualify restore timer
    assign restore_arm = ~s_r.psi_mode & output_in_regulation &
                         (s_r.state == mode_pkg::ST_RUN);

    // strap decode; an unknown code falls back to one phase
    // phase-count decode
    always_comb begin
        case (phase_count_strap)
            mode_pkg::PH_STRAP_6: ph_strap_mask = mode_pkg::PH_MASK_6;
            mode_pkg::PH_STRAP_4: ph_strap_mask = mode_pkg::PH_MASK_4;
            mode_pkg::PH_STRAP_3: ph_strap_mask = mode_pkg::PH_MASK_3;
            mode_pkg::PH_STRAP_2: ph_strap_mask = mode_pkg::PH_MASK_2;
            mode_pkg::PH_STRAP_1: ph_strap_mask = mode_pkg::PH_MASK_1;
            default:              ph_strap_mask = mode_pkg::PH_MASK_1;
        endcase
    end

    // next-state logic: registers, sequencing, ramp, power mode
    always_comb begin
        s_nxt         = s_r;
        s_nxt.enabled = enabled_now;
        s_nxt.rdata   = 32'h00000000;

        // read answers in the following cycle; unmapped reads zero
        if (rd_stb) begin
            case (addr)
                mode_pkg::ADDR_CTRL: s_nxt.rdata = {29'h0, s_r.slew};
                mode_pkg::ADDR_BOOT: s_nxt.rdata = {24'h0, s_r.boot};
                mode_pkg::ADDR_VID:  s_nxt.rdata = {24'h0, s_r.vid};
                mode_pkg::ADDR_STAT: begin
                    s_nxt.rdata = {10'h0, s_r.ph_mask, s_r.target,
                                   s_r.state, s_r.psi_mode,
                                   s_r.light, s_r.full, 1'b0,
                                   s_r.enabled};
                end
                default:             s_nxt.rdata = 32'h00000000;
            endcase
        end

        // writes; unmapped and status writes are ignored
        if (wr_stb) begin
            case (addr)
                mode_pkg::ADDR_CTRL: s_nxt.slew = wdata[2:0];
                mode_pkg::ADDR_BOOT: s_nxt.boot = wdata[7:0];
                mode_pkg::ADDR_VID:  s_nxt.vid  = wdata[7:0];
                default:             s_nxt.vid  = s_nxt.vid;
            endcase
        end

        // one-code ramp of the target toward the goal
        if (running && (s_r.target != s_nxt.vid)) begin
            if (s_r.step_cnt == 16'h0000) begin
                s_nxt.step_cnt = step_len - 16'h0001;
                if (s_r.target < s_nxt.vid) begin
                    s_nxt.target = s_r.target + 8'h01;
                end else begin
                    s_nxt.target = s_r.target - 8'h01;
                end
            end else begin
                s_nxt.step_cnt = s_r.step_cnt - 16'h0001;
            end
        end else begin
            s_nxt.step_cnt = step_len - 16'h0001;
        end

        if (!enabled_now) begin
            s_nxt.state  = mode_pkg::ST_OFF;
            s_nxt.target = 8'h00;
            s_nxt.full   = 1'b1;
            s_nxt.light  = 1'b0;
        end else begin
            case (s_r.state)
                mode_pkg::ST_OFF: begin
                    // straps are taken once per enable
                    // sample function strap
                    s_nxt.psi_mode = function_select_strap;
                    s_nxt.ph_mask  = ph_strap_mask;
                    s_nxt.state    = mode_pkg::ST_WAIT_STAGE;
                end
                mode_pkg::ST_WAIT_STAGE: begin
                    if (stage_supply_good) begin
                        s_nxt.vid   = s_r.boot;
                        s_nxt.state = mode_pkg::ST_SOFT_START;
                    end
                end
                mode_pkg::ST_SOFT_START: begin
                    if (!stage_supply_good) begin
                        s_nxt.state  = mode_pkg::ST_WAIT_STAGE;
                        s_nxt.target = 8'h00;
                    end else if (s_r.target == s_nxt.vid) begin
                        s_nxt.state = mode_pkg::ST_RUN;
                    end
                end
                mode_pkg::ST_RUN: begin
                    if (!stage_supply_good) begin
                        s_nxt.state  = mode_pkg::ST_WAIT_STAGE;
                        s_nxt.target = 8'h00;
                    end else if (restore_fire) begin
                        s_nxt.vid   = s_r.boot;
                        s_nxt.state = mode_pkg::ST_RESTORE;
                    end
                end
                mode_pkg::ST_RESTORE: begin
                    if (!stage_supply_good) begin
                        s_nxt.state  = mode_pkg::ST_WAIT_STAGE;
                        s_nxt.target = 8'h00;
                    end else if (s_r.target == s_nxt.vid) begin
                        s_nxt.state = mode_pkg::ST_RUN;
                    end
                end
                default: begin
                    s_nxt.state = mode_pkg::ST_OFF;
                end
            endcase

            // power mode follows the level only once regulating;
            // before that the block holds its last mode, full power after enable
            // change after regulation
            if (s_r.psi_mode && output_in_regulation &&
                (s_r.state == mode_pkg::ST_RUN ||
                 s_r.state == mode_pkg::ST_RESTORE)) begin
                s_nxt.full  = multi_function_pin;
                s_nxt.light = ~multi_function_pin;
            end else if (!s_r.psi_mode) begin
                s_nxt.full  = 1'b1;
                s_nxt.light = 1'b0;
            end
        end
    end

    // state register; straps are caught later, in the off state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.state    <= mode_pkg::ST_OFF;
            s_r.target   <= 8'h00;
            s_r.vid      <= mode_pkg::VID_RST;
            s_r.boot     <= mode_pkg::BOOT_RST;
            s_r.slew     <= mode_pkg::SLEW_RST;
            s_r.step_cnt <= 16'h0000;
            s_r.psi_mode <= 1'b0;
            s_r.ph_mask  <= mode_pkg::PH_MASK_1;
            s_r.enabled  <= 1'b0;
            s_r.full     <= 1'b1;
            s_r.light    <= 1'b0;
            s_r.rdata    <= 32'h00000000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // phase selection toward the output stage
    // full power uses strap
    assign dif.phase_en  = s_r.light ? mode_pkg::PH_MASK_1 : s_r.ph_mask;
    assign dif.pwm_raw   = modulator_pwm;
    // float in off and stage wait, on mid-level request, or on disable;
    // the live enable term saves a cycle on shutdown
    // mid-level floats
    assign dif.float_all = ~running | fault_mid_level | ~enabled_now;

    // restore low-time measurement
    restore_timer #(
        .LIMIT (RESTORE_CYC)
    ) u_restore (
        .clk       (clk),
        .rst_n     (rst_n),
        .armed     (restore_arm),
        .request_n (multi_function_pin),
        .fire      (restore_fire)
    );

    // tri-level drive codes and pin enables
    // six tri-level outputs
    pwm_stage u_stage (
        .clk   (clk),
        .rst_n (rst_n),
        .dif   (dif)
    );

    // outputs come from flip-flops
    assign pwm_drive_hi     = dif.pin_hi;
    assign pwm_drive_oe     = dif.pin_oe;
    assign target_code      = s_r.target;
    assign device_enabled   = s_r.enabled;
    assign full_power_state = s_r.full;
    assign light_load_state = s_r.light;
    assign rdata            = s_r.rdata;
endmodule // phase_mode_ctrl

// ---- stage_model.sv ----
`timescale 1ns/1ps
// power stages on the far side: supply good after a settle time,
// and the level each pwm input sees
module stage_model #(
    parameter int unsigned GOOD_DLY = 6  // supply settle, in cycles
) (
    // clock
    input  wire logic       clk,
    // supply switch from the bench
    input  wire logic       supply_on,
    // pins from the controller
    input  wire logic [5:0] pwm_drive_hi,
    input  wire logic [5:0] pwm_drive_oe,
    // toward controller and bench
    output logic            stage_supply_good,
    output logic [11:0]     seen_level
);
    int unsigned cnt_r = 0;  // settle counter

    // supply good rises late, drops at once
    always_ff @(posedge clk) begin
        if (!supply_on) cnt_r <= 0;
        else if (cnt_r < GOOD_DLY) cnt_r <= cnt_r + 1;
    end
    assign stage_supply_good = (cnt_r == GOOD_DLY);

    // an undriven pin settles at mid-level
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            seen_level[2*i +: 2] = !pwm_drive_oe[i] ? mode_pkg::DRV_FLOAT
                : (pwm_drive_hi[i] ? mode_pkg::DRV_HIGH : mode_pkg::DRV_LOW);
        end
    end
endmodule // stage_model

// ---- phase_mode_ctrl_assertions.sv ----
`timescale 1ns/1ps
// watches pin drive and mode flags at the top ports
module mode_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // monitors, straps, pin
    input wire logic       en_above_threshold,
    input wire logic       supply_lockout,
    input wire logic       stage_supply_good,
    input wire logic       output_in_regulation,
    input wire logic       fault_mid_level,
    input wire logic       function_select_strap,
    input wire logic [2:0] phase_count_strap,
    input wire logic       multi_function_pin,
    // outputs under watch
    input wire logic [5:0] pwm_drive_hi,
    input wire logic [5:0] pwm_drive_oe,
    input wire logic [7:0] target_code,
    input wire logic       device_enabled,
    input wire logic       full_power_state,
    input wire logic       light_load_state
);
    // phases per strap code; codes above four give one phase
    localparam logic [5:0] MASKS [5] = '{6'h3f, 6'h0f, 6'h07, 6'h03, 6'h01};
    logic [5:0] smask;  // phases the strap allows
    assign smask = phase_count_strap > 3'h4 ? 6'h01
                 : MASKS[phase_count_strap];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    en_on_a: assert property (
        en_above_threshold && !supply_lockout |=> device_enabled)
        else $error("enable flag missing");
    off_float_a: assert property (
        !en_above_threshold || supply_lockout
        |=> !device_enabled && pwm_drive_oe == 6'h00)
        else $error("pins driven while off");
    fault_float_a: assert property (
        fault_mid_level |=> pwm_drive_oe == 6'h00)
        else $error("pins driven in mid-level request");
    float_code_a: assert property (
        (pwm_drive_hi & ~pwm_drive_oe) == 6'h00)
        else $error("floating pin shows high");
    light_one_a: assert property (
        light_load_state && $past(light_load_state)
        |-> pwm_drive_oe[5:1] == 5'h00)
        else $error("extra phase in light load");
    strap_mask_a: assert property (
        $stable(phase_count_strap) |-> (pwm_drive_oe & ~smask) == 6'h00)
        else $error("phase outside strap mask");
    mode_gate_a: assert property (
        $rose(light_load_state) |-> $past(output_in_regulation))
        else $error("mode change before regulation");
    psi_low_a: assert property (
        $rose(light_load_state)
        |-> $past(!multi_function_pin) && $past(function_select_strap))
        else $error("light load without low level");
    stage_drop_a: assert property (
        $fell(stage_supply_good) |-> ##[1:2] target_code == 8'h00)
        else $error("target kept after stage loss");
    ramp_step_a: assert property (
        $changed(target_code) && device_enabled
        && $past(device_enabled) && $past(stage_supply_good)
        |-> target_code - $past(target_code) == 8'h01
         || $past(target_code) - target_code == 8'h01)
        else $error("target moved by more than one");

    light_c: cover property (light_load_state);
    six_c: cover property (full_power_state && pwm_drive_oe == 6'h3f);
    boot_c: cover property (target_code == 8'h08 && !multi_function_pin);
endmodule // mode_checker

bind phase_mode_ctrl mode_checker u_mode_checker (
    .clk, .rst_n, .en_above_threshold, .supply_lockout,
    .stage_supply_good, .output_in_regulation, .fault_mid_level,
    .function_select_strap, .phase_count_strap, .multi_function_pin,
    .pwm_drive_hi, .pwm_drive_oe, .target_code, .device_enabled,
    .full_power_state, .light_load_state
);

// ---- phase_mode_ctrl_tb_top.sv ----
`timescale 1ns/1ps
// reads are noted in a queue and judged by the monitor; pins each cycle
module phase_mode_ctrl_tb_top;
    localparam int unsigned RCYC = 20;  // short restore hold-off
    localparam logic [5:0] MASKS [5] = '{6'h3f, 6'h0f, 6'h07, 6'h03, 6'h01};
    logic        clk = 1'b0;
    logic        rst_n, wr_stb, rd_stb, en_above_threshold, supply_lockout;
    logic        output_in_regulation, fault_mid_level, multi_function_pin;
    logic        function_select_strap, supply_on, stage_supply_good;
    logic        device_enabled, full_power_state, light_load_state;
    logic [7:0]  addr, target_code;
    logic [31:0] wdata, rdata;
    logic [2:0]  phase_count_strap;
    logic [5:0]  modulator_pwm, pwm_drive_hi, pwm_drive_oe, mod_q, exp_mask;
    logic [11:0] seen_level;
    logic [15:0] lf = 16'hfc9d;   // seed 64669
    logic        rd_d = 1'b0;     // read issued last cycle
    logic        chk_pins = 1'b0; // pin comparison on
    logic [63:0] exp_q [$];       // {mask, value} per read
    int          err_total = 0;
    int          num_checks = 0;
    int          waited;

    phase_mode_ctrl #(.RESTORE_CYC(RCYC)) u_phase_mode_ctrl (.*);
    stage_model u_stage_model (
        .clk, .supply_on, .pwm_drive_hi, .pwm_drive_oe,
        .stage_supply_good, .seen_level
    );

    always #2.5 clk = ~clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic end_sim;
        if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one bus cycle; strobes stay up until the next call or idle
    task automatic bus(input logic r, input logic [7:0] a,
                       input logic [31:0] d);
        rd_stb <= r;
        wr_stb <= !r;
        addr   <= a;
        wdata  <= d;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back({m, e});
        bus(1'b1, a, 32'h0);
    endtask

    task automatic idle;
        rd_stb <= 1'b0;
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask

    // bounded wait for a target code, seen between edges
    task automatic wait_t(input logic [7:0] t);
        waited = 0;
        do begin
            @(negedge clk);
            waited++;
        end while (target_code !== t && waited < 3000);
        chk(32'(target_code), 32'(t));
        @(posedge clk);
    endtask

    task automatic up(input logic fn, input logic [2:0] s);
        function_select_strap <= fn;
        phase_count_strap     <= s;
        supply_on             <= 1'b1;
        en_above_threshold    <= 1'b1;
        wait_t(8'h08);
        output_in_regulation  <= 1'b1;
        // unused strap codes fall back to one phase
        exp_mask = s > 3'h4 ? 6'h01 : MASKS[s];
        chk_pins <= 1'b1;
        cyc(3);
    endtask

    task automatic down;
        en_above_threshold   <= 1'b0;
        supply_lockout       <= 1'b0;
        output_in_regulation <= 1'b0;
        supply_on            <= 1'b0;
        chk_pins             <= 1'b0;
        cyc(2);
        @(negedge clk);
        chk(32'(pwm_drive_oe), 32'h0);
        @(posedge clk);
    endtask

    // random modulator levels, read tracking
    always @(posedge clk) begin
        lf            <= lfsr(lf);
        modulator_pwm <= lf[5:0];
        mod_q         <= modulator_pwm;
        rd_d          <= rd_stb;
    end

    // monitor: read data and pin drive, between edges
    always @(negedge clk) begin
        if (chk_pins) begin
            chk(32'(pwm_drive_oe), 32'(exp_mask));
            chk(32'(pwm_drive_hi), 32'(mod_q & exp_mask));
        end
        if (rd_d && exp_q.size() > 0) begin
            chk(rdata & exp_q[0][63:32], exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
    end

    // watchdog, far beyond the planned run
    initial begin
        cyc(40000);
        err_total++;
        end_sim();
    end

    initial begin
        // enable input driven from time zero
        en_above_threshold = 1'b0;
        rst_n = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0; addr = 8'h00;
        wdata = 32'h0; supply_lockout = 1'b0; output_in_regulation = 1'b0;
        fault_mid_level = 1'b0; function_select_strap = 1'b0;
        phase_count_strap = 3'h0; multi_function_pin = 1'b1;
        supply_on = 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        // reset values, unmapped read, back-to-back writes
        rd(mode_pkg::ADDR_CTRL, 32'h0, 32'h7);
        rd(mode_pkg::ADDR_BOOT, 32'h40, 32'hff);
        rd(mode_pkg::ADDR_VID, 32'h0, 32'hff);
        rd(8'h10, 32'h0, 32'hffffffff);
        rd(mode_pkg::ADDR_STAT, 32'h04, 32'hff);
        bus(1'b0, mode_pkg::ADDR_CTRL, 32'h7);
        bus(1'b0, mode_pkg::ADDR_BOOT, 32'h08);
        bus(1'b0, mode_pkg::ADDR_STAT, 32'hff);
        rd(mode_pkg::ADDR_CTRL, 32'h7, 32'h7);
        rd(mode_pkg::ADDR_BOOT, 32'h08, 32'hff);
        rd(mode_pkg::ADDR_STAT, 32'h04, 32'hff);
        idle();
        // every phase-count strap in full power
        for (int s = 0; s < 8; s++) begin
            up(1'b1, 3'(s));
            cyc(20);
            rd(mode_pkg::ADDR_STAT, {10'h0, exp_mask, 16'h0875},
               32'h3fffff);
            idle();
            down();
        end
        // power saving: held before regulation, then single phase
        up(1'b1, 3'h1);
        chk_pins <= 1'b0;
        output_in_regulation <= 1'b0;
        multi_function_pin <= 1'b0;
        cyc(5);
        chk(32'(light_load_state), 32'h0);
        output_in_regulation <= 1'b1;
        cyc(4);
        chk(32'(full_power_state), 32'h0);
        exp_mask = 6'h01;
        chk_pins <= 1'b1;
        rd(mode_pkg::ADDR_STAT, 32'h08, 32'h0c);
        idle();
        cyc(20);
        chk_pins <= 1'b0;
        multi_function_pin <= 1'b1;
        cyc(4);
        chk(32'(full_power_state), 32'h1);
        exp_mask = 6'h0f;
        chk_pins <= 1'b1;
        cyc(10);
        // mid-level request, then lockout
        fault_mid_level <= 1'b1;
        chk_pins <= 1'b0;
        cyc(2);
        chk(32'(seen_level), 32'haaa);
        fault_mid_level <= 1'b0;
        supply_lockout <= 1'b1;
        cyc(2);
        chk(32'(device_enabled), 32'h0);
        down();
        // stage supply lost in run, then recovered
        up(1'b1, 3'h0);
        supply_on <= 1'b0;
        chk_pins <= 1'b0;
        cyc(4);
        chk(32'(target_code), 32'h0);
        chk(32'(seen_level), 32'haaa);
        rd(mode_pkg::ADDR_STAT, 32'h20, 32'he0);
        idle();
        supply_on <= 1'b1;
        wait_t(8'h08);
        down();
        // restore: short low ignored, long low returns to boot
        up(1'b0, 3'h0);
        bus(1'b0, mode_pkg::ADDR_VID, 32'h0c);
        idle();
        wait_t(8'h0c);
        multi_function_pin <= 1'b0;
        cyc(RCYC);
        chk(32'(light_load_state), 32'h0);
        multi_function_pin <= 1'b1;
        cyc(20);
        chk(32'(target_code), 32'h0c);
        multi_function_pin <= 1'b0;
        wait_t(8'h0b);
        wait_t(8'h08);
        chk(32'(waited), 32'h18);
        multi_function_pin <= 1'b1;
        down();
        end_sim();
    end
endmodule // phase_mode_ctrl_tb_top
